// ### pkg/ccm_consts.svh
// How it works
// RL1 - PWM runs 16-bit when wide select is set, else 8 to 11-bit.
// RL2 - counter is compared against the compare register only while comparator enabled, except in PWM mode.
// RL3 - rising pin edges capture only while rising capture enable is set.
// RL4 - falling pin edges capture only while falling capture enable is set.
// RL5 - with match enabled, every counter equality sets the event flag.
// RL6 - with toggle enabled, every counter equality inverts the output pin.
// RL7 - with PWM enabled, a pulse-width-modulated waveform drives the output pin.
// RL8 - toggle and PWM enabled together select frequency output mode instead.
// RL9 - interrupt request follows the event flag only when flag interrupt enabled.
// RL10 - a selected capture edge copies the counter and sets the event flag.
// RL11 - all eight mode bits read and write, and reset to zero.
`ifndef CCM_CONSTS_SVH
`define CCM_CONSTS_SVH

// mode register and its bit positions
`define CCM_MODE_ADDR 8'hDB
`define CCM_MODE_RESET 8'h00
`define CCM_BIT_WIDE_PWM 7
`define CCM_BIT_COMP_EN 6
`define CCM_BIT_RISE_CAP 5
`define CCM_BIT_FALL_CAP 4
`define CCM_BIT_MATCH 3
`define CCM_BIT_TOGGLE 2
`define CCM_BIT_PWM 1
`define CCM_BIT_FLAG_IE 0

// compare register bytes
`define CCM_CCR_LO_ADDR 8'hE9
`define CCM_CCR_HI_ADDR 8'hEA
`define CCM_CCR_RESET 16'h0000
`define CCM_PWM_BASE_BITS 8

`endif

// ### pkg/ccm_pkg.sv
package ccm_pkg;

  typedef struct packed {
    logic wide_pwm_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic flag_interrupt_enable;
  } mode_bits_t;

  typedef enum logic [1:0] {
    OUT_NONE,
    OUT_TOGGLE,
    OUT_PWM,
    OUT_FREQ
  } out_fn_t;

endpackage : ccm_pkg

// ### pkg/ccm_cmp_if.sv
`timescale 1ns/1ps
interface ccm_cmp_if;
  logic [15:0] cnt;
  logic [15:0] ccr;
  logic wide;
  logic freq;
  logic [1:0] pwm_extra_bits;
  logic match_eq;
  logic pwm_high;

  modport core (
    output cnt, ccr, wide, freq, pwm_extra_bits,
    input match_eq, pwm_high
  );
  modport unit (
    input cnt, ccr, wide, freq, pwm_extra_bits,
    output match_eq, pwm_high
  );
endinterface : ccm_cmp_if

// ### logic/ccm_compare.sv
`timescale 1ns/1ps
module ccm_compare (
  ccm_cmp_if.unit cmp
);

  logic [15:0] mask;
  logic [15:0] cnt_m;
  logic [15:0] ccr_m;

  // narrow PWM compares only the low 8 to 11 counter bits
  always_comb begin
    if (cmp.wide) begin
      mask = 16'hFFFF; // RL1
    end else if (cmp.freq) begin
      mask = 16'h00FF;
    end else begin
      mask = 16'h07FF >> (2'd3 - cmp.pwm_extra_bits); // RL1
    end
    cnt_m = cmp.cnt & mask;
    ccr_m = cmp.ccr & mask;
    cmp.match_eq = (cnt_m == ccr_m);
    cmp.pwm_high = (cnt_m >= ccr_m);
  end

endmodule : ccm_compare

// ### logic/ccm_module.sv
`timescale 1ns/1ps
`include "ccm_consts.svh"
module ccm_module (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [15:0] counter_i,
  input wire logic [1:0] pwm_extra_bits_i,
  input wire logic flag_clear_i,
  input wire logic io_pin_i,
  output logic [7:0] sfr_rdata_o,
  output logic io_pin_o,
  output logic io_pin_oe_o,
  output logic event_flag_o,
  output logic irq_o
);

  ccm_pkg::mode_bits_t mode_q;
  logic [15:0] ccr_q;
  logic pin_prev_q;
  logic eq_prev_q;
  logic out_q;
  logic flag_q;
  logic irq_q;
  logic [7:0] rdata_q;
  logic oe_q;
  ccm_pkg::out_fn_t out_fn;
  logic rise_ev;
  logic fall_ev;
  logic capture_ev;
  logic match_ev;
  logic wr_mode;
  logic wr_lo;
  logic wr_hi;

  ccm_cmp_if cmp ();

  ccm_compare u_compare (
    .cmp(cmp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode

  assign wr_mode = sfr_wr_i && (sfr_addr_i == `CCM_MODE_ADDR);
  assign wr_lo = sfr_wr_i && (sfr_addr_i == `CCM_CCR_LO_ADDR);
  assign wr_hi = sfr_wr_i && (sfr_addr_i == `CCM_CCR_HI_ADDR);

  always_comb begin
    unique case ({mode_q.toggle_enable, mode_q.pwm_enable})
      2'b11: out_fn = ccm_pkg::OUT_FREQ; // RL8
      2'b10: out_fn = ccm_pkg::OUT_TOGGLE;
      2'b01: out_fn = ccm_pkg::OUT_PWM;
      2'b00: out_fn = ccm_pkg::OUT_NONE;
    endcase
  end

  assign cmp.cnt = counter_i;
  assign cmp.ccr = ccr_q;
  assign cmp.wide = mode_q.wide_pwm_select;
  assign cmp.freq = (out_fn == ccm_pkg::OUT_FREQ);
  assign cmp.pwm_extra_bits = pwm_extra_bits_i;

  assign rise_ev = mode_q.rising_capture_enable && io_pin_i && !pin_prev_q; // RL3
  assign fall_ev = mode_q.falling_capture_enable && !io_pin_i && pin_prev_q; // RL4
  assign capture_ev = rise_ev || fall_ev;
  // one event per equality, not one per cycle while the counter rests on it
  assign match_ev = mode_q.comparator_enable && cmp.match_eq && !eq_prev_q; // RL2

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mode_q <= ccm_pkg::mode_bits_t'(`CCM_MODE_RESET); // RL11
    end else if (wr_mode) begin
      mode_q <= ccm_pkg::mode_bits_t'(sfr_wdata_i); // RL11
    end
  end

  // capture outranks a software write in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ccr_q <= `CCM_CCR_RESET;
    end else if (capture_ev) begin
      ccr_q <= counter_i; // RL10
    end else if (match_ev && out_fn == ccm_pkg::OUT_FREQ) begin
      ccr_q[7:0] <= ccr_q[7:0] + ccr_q[15:8]; // RL8
    end else if (wr_lo) begin
      ccr_q[7:0] <= sfr_wdata_i;
    end else if (wr_hi) begin
      ccr_q[15:8] <= sfr_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        `CCM_MODE_ADDR: rdata_q <= mode_q; // RL11
        `CCM_CCR_LO_ADDR: rdata_q <= ccr_q[7:0];
        `CCM_CCR_HI_ADDR: rdata_q <= ccr_q[15:8];
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge history

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_prev_q <= 1'b0;
      eq_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= io_pin_i;
      eq_prev_q <= cmp.match_eq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag and request; set wins over clear

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      flag_q <= 1'b0;
    end else if (capture_ev || (match_ev && mode_q.match_flag_enable)) begin
      flag_q <= 1'b1; // RL5 RL10
    end else if (flag_clear_i) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q && mode_q.flag_interrupt_enable; // RL9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output pin

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= (out_fn != ccm_pkg::OUT_NONE);
      unique case (out_fn)
        ccm_pkg::OUT_TOGGLE, ccm_pkg::OUT_FREQ: begin
          if (match_ev) begin
            out_q <= !out_q; // RL6 RL8
          end
        end
        ccm_pkg::OUT_PWM: out_q <= cmp.pwm_high; // RL7 RL1
        ccm_pkg::OUT_NONE: out_q <= out_q;
      endcase
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign io_pin_o = out_q;
  assign io_pin_oe_o = oe_q;
  assign event_flag_o = flag_q;
  assign irq_o = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_rise_seen;
    !io_pin_i ##1 io_pin_i;
  endsequence

  sequence s_fall_seen;
    io_pin_i ##1 !io_pin_i;
  endsequence

  // write, one idle cycle, then a read of the same register
  a_mode_readback: assert property ( // RL11
    wr_mode ##1 !wr_mode ##1 (sfr_rd_i && sfr_addr_i == `CCM_MODE_ADDR && !wr_mode)
      |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
    else $error("mode register did not read back");

  // enable is judged in the cycle the new pin level is seen
  a_rise_capture: assert property ( // RL3
    s_rise_seen ##0 mode_q.rising_capture_enable
      |=> ccr_q == $past(counter_i) && event_flag_o)
    else $error("rising edge not captured");

  a_fall_capture: assert property ( // RL4
    s_fall_seen ##0 mode_q.falling_capture_enable
      |=> ccr_q == $past(counter_i) && event_flag_o)
    else $error("falling edge not captured");

  a_no_capture: assert property ( // RL10
    !capture_ev && !wr_lo && !wr_hi && !(match_ev && cmp.freq) |=> $stable(ccr_q))
    else $error("compare register changed without cause");

  a_match_flag: assert property ( // RL5
    match_ev && mode_q.match_flag_enable |=> event_flag_o)
    else $error("match did not set flag");

  a_comp_gate: assert property ( // RL2
    !mode_q.comparator_enable && !capture_ev |=> !event_flag_o || $past(event_flag_o))
    else $error("flag set with comparator off");

  a_toggle_pin: assert property ( // RL6
    match_ev && out_fn == ccm_pkg::OUT_TOGGLE |=> io_pin_o != $past(io_pin_o))
    else $error("pin did not toggle on match");

  a_pwm_level: assert property ( // RL7
    out_fn == ccm_pkg::OUT_PWM |=> io_pin_o == $past(cmp.pwm_high))
    else $error("pwm level wrong");

  a_freq_step: assert property ( // RL8
    match_ev && cmp.freq && !capture_ev
      |=> ccr_q[7:0] == 8'($past(ccr_q[7:0]) + $past(ccr_q[15:8])))
    else $error("frequency step not added");

  a_irq_mask: assert property ( // RL9
    irq_o == $past(flag_q && mode_q.flag_interrupt_enable))
    else $error("interrupt request mismatch");

  a_wide_full: assert property ( // RL1
    mode_q.wide_pwm_select && !cmp.freq |-> cmp.match_eq == (counter_i == ccr_q))
    else $error("wide pwm not full width");

endmodule : ccm_module

// ### test/pin_model.sv
`timescale 1ns/1ps
module pin_model (
  input wire logic drive_lvl_i,
  input wire logic dut_o_i,
  input wire logic dut_oe_i,
  output logic pin_o
);
  // far side lets go of the pin while the module drives it
  assign pin_o = dut_oe_i ? dut_o_i : drive_lvl_i;
endmodule : pin_model

// ### test/testbench.sv
`timescale 1ns/1ps
`include "ccm_consts.svh"
module testbench;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] cnt = 16'h0000;
  logic [1:0] extra = 2'h0;
  logic fclr = 1'b0;
  logic lvl = 1'b0;
  logic pin;
  logic [7:0] rdata;
  logic pin_o;
  logic pin_oe;
  logic flag;
  logic irq;
  int n_errors = 0;
  int comparisons = 0;

  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  ccm_module ccm_module_i (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .sfr_addr_i(addr),
    .sfr_wdata_i(wdata),
    .sfr_wr_i(wr),
    .sfr_rd_i(rd),
    .counter_i(cnt),
    .pwm_extra_bits_i(extra),
    .flag_clear_i(fclr),
    .io_pin_i(pin),
    .sfr_rdata_o(rdata),
    .io_pin_o(pin_o),
    .io_pin_oe_o(pin_oe),
    .event_flag_o(flag),
    .irq_o(irq)
  );

  pin_model pin_model_i (
    .drive_lvl_i(lvl),
    .dut_o_i(pin_o),
    .dut_oe_i(pin_oe),
    .pin_o(pin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask : rd_chk

  task automatic rst(input int n);
    srst_i = 1'b1;
    cyc(n);
    srst_i = 1'b0;
    cyc(1);
  endtask : rst

  // pin or counter change, then let the registered outputs settle
  task automatic step(input logic l, input logic [15:0] c);
    lvl = l;
    cnt = c;
    cyc(3);
  endtask : step

  task automatic clr_flag;
    fclr = 1'b1;
    cyc(1);
    fclr = 1'b0;
    cyc(2);
  endtask : clr_flag

  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst(20);
    chk("oe", 16'h0000, 16'(pin_oe));
    chk("flag irq", 16'h0000, 16'({flag, irq}));
    rd_chk(`CCM_MODE_ADDR, `CCM_MODE_RESET, "mode");
    wr_reg(`CCM_MODE_ADDR, 8'hA5);
    rd_chk(`CCM_MODE_ADDR, 8'hA5, "mode");
    wr_reg(`CCM_MODE_ADDR, 8'h5A);
    rd_chk(`CCM_MODE_ADDR, 8'h5A, "mode");
    wr_reg(8'h01, 8'hFF);
    rd_chk(8'h01, 8'h00, "unmapped");
    // a reset in mid-run must clear the mode again
    rst(2);
    chk("oe", 16'h0000, 16'(pin_oe));
    rd_chk(`CCM_MODE_ADDR, `CCM_MODE_RESET, "mode");
    // capture edges
    wr_reg(`CCM_MODE_ADDR, 8'h21);
    step(1'b1, 16'h1234);
    chk("flag irq", 16'h0003, 16'({flag, irq}));
    rd_chk(`CCM_CCR_LO_ADDR, 8'h34, "ccr lo");
    rd_chk(`CCM_CCR_HI_ADDR, 8'h12, "ccr hi");
    clr_flag();
    step(1'b0, 16'h1111);
    chk("flag", 16'h0000, 16'(flag));
    wr_reg(`CCM_MODE_ADDR, 8'h11);
    step(1'b1, 16'h5678);
    chk("flag", 16'h0000, 16'(flag));
    step(1'b0, 16'h5678);
    chk("flag", 16'h0001, 16'(flag));
    rd_chk(`CCM_CCR_LO_ADDR, 8'h78, "ccr lo");
    clr_flag();
    wr_reg(`CCM_MODE_ADDR, 8'h20);
    step(1'b1, 16'h0000);
    chk("flag irq", 16'h0002, 16'({flag, irq}));
    // match, first without the comparator
    rst(2);
    wr_reg(`CCM_CCR_LO_ADDR, 8'h10);
    wr_reg(`CCM_MODE_ADDR, 8'h08);
    step(1'b0, 16'h0010);
    chk("flag", 16'h0000, 16'(flag));
    step(1'b0, 16'h000F);
    wr_reg(`CCM_MODE_ADDR, 8'h48);
    step(1'b0, 16'h0010);
    chk("flag", 16'h0001, 16'(flag));
    // toggle on every match; counter leaves the compare value first
    rst(2);
    wr_reg(`CCM_CCR_LO_ADDR, 8'h10);
    wr_reg(`CCM_MODE_ADDR, 8'h44);
    chk("oe pin", 16'h0002, 16'({pin_oe, pin_o}));
    step(1'b0, 16'h0011);
    step(1'b0, 16'h0010);
    chk("pin", 16'h0001, 16'(pin_o));
    step(1'b0, 16'h0011);
    step(1'b0, 16'h0010);
    chk("pin", 16'h0000, 16'(pin_o));
    // narrow and wide pwm against the same compare value
    rst(2);
    wr_reg(`CCM_CCR_LO_ADDR, 8'h80);
    wr_reg(`CCM_MODE_ADDR, 8'h42);
    step(1'b0, 16'h017F);
    chk("pwm8", 16'h0000, 16'(pin_o));
    step(1'b0, 16'h0180);
    chk("pwm8", 16'h0001, 16'(pin_o));
    extra = 2'h1;
    step(1'b0, 16'h017F);
    chk("pwm9", 16'h0001, 16'(pin_o));
    extra = 2'h2;
    step(1'b0, 16'h047F);
    chk("pwm10", 16'h0000, 16'(pin_o));
    extra = 2'h3;
    step(1'b0, 16'h047F);
    chk("pwm11", 16'h0001, 16'(pin_o));
    wr_reg(`CCM_MODE_ADDR, 8'hC2);
    step(1'b0, 16'h0050);
    chk("wide_pwm_select", 16'h0000, 16'(pin_o));
    step(1'b0, 16'h017F);
    chk("wide_pwm_select", 16'h0001, 16'(pin_o));
    // frequency output: reload moves the next match to 0x30, then 0x50
    rst(2);
    wr_reg(`CCM_CCR_LO_ADDR, 8'h10);
    wr_reg(`CCM_CCR_HI_ADDR, 8'h20);
    wr_reg(`CCM_MODE_ADDR, 8'h46);
    step(1'b0, 16'h0010);
    chk("freq", 16'h0001, 16'(pin_o));
    step(1'b0, 16'h0030);
    chk("freq", 16'h0000, 16'(pin_o));
    rd_chk(`CCM_CCR_LO_ADDR, 8'h50, "freq reload");
    final_report();
  end

  // the tests need well under 500 cycles
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule : testbench
